// File: src/port_pullup_enable_control.sv
// Per-pin pull-up enable control for two 8-bit ports, reached over APB.
// Assumes synchronous pin configuration inputs on clk_sys and an APB
// master that keeps each request steady until pready is seen high.
//
// Added by the designer: the APB interface to the registers.
`include "pullup_map.svh"
`default_nettype none

// Behaviour
// - Second port register: eight read/write pull bits
// - Second port bit 1 enables, 0 disables
// - Second port register clears on reset
// - Pull acts only on pins used as inputs
// - First port bits 7..5 and 3..0 switch pulls
// - First port bit 4 reads zero, ignores writes
module port_pullup_enable_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB request
  input wire pullup_pkg::apb_req_t apb_req,
  // APB answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // First port pin configuration
  input wire logic [7:0] first_port_out_en,
  input wire logic [7:0] first_port_in_en,
  // Second port pin configuration
  input wire logic [7:0] second_port_out_en,
  input wire logic [7:0] second_port_in_en,
  // Pull-up device controls to the pads
  output logic [7:0] first_port_pin_pull_on,
  output logic [7:0] second_port_pin_pull_on
);
  import pullup_pkg::*;

  // ==========================================================
  // Address decode

  // Hit vector {second, first}; used by both read and write paths
  function automatic logic [1:0] reg_hit(input logic [15:0] addr);
    logic [17:0] first_a;
    logic [17:0] second_a;
    first_a = {`FIRST_PULL_IDX, 2'b00};
    second_a = {`SECOND_PULL_IDX, 2'b00};
    reg_hit = 2'b00;
    // Only the low 16 bits of the byte address reach the slave
    if (addr == first_a[15:0]) begin
      reg_hit = 2'b01;
    end else if (addr == second_a[15:0]) begin
      reg_hit = 2'b10;
    end
  endfunction

  // ==========================================================
  // State

  apb_state_t state_r; // Bus phase
  apb_state_t state_nxt;
  logic pready_r; // Access phase answer
  logic pready_nxt;
  logic pslverr_r; // Unmapped address answer
  logic pslverr_nxt;
  logic [31:0] prdata_r; // Read data for the access phase
  logic [31:0] prdata_nxt;
  pull_regs_t regs_r; // Stored enables
  pull_regs_t regs_nxt;
  logic [7:0] pull_first_r; // Gated pad controls
  logic [7:0] pull_first_nxt;
  logic [7:0] pull_second_r;
  logic [7:0] pull_second_nxt;

  // Phase qualifiers
  logic setup_ph; // First cycle of a transfer
  logic access_done; // Edge that completes a transfer
  logic [1:0] hit; // Current address decode

  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign access_done = apb_req.psel & apb_req.penable & pready_r;
  assign hit = reg_hit(apb_req.paddr);

  // ==========================================================
  // Bus phase and answers

  // Answer is prepared in setup so it can come from flops; zero wait
  always_comb begin
    state_nxt = state_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = `RDATA_ZERO;
    case (state_r)
      ST_IDLE: begin
        // Setup seen: answer in the access cycle
        if (setup_ph) begin
          state_nxt = ST_ACC;
          pready_nxt = 1'b1;
          pslverr_nxt = (hit == 2'b00);
          if (!apb_req.pwrite) begin
            // Stored values are returned as they are
            if (hit[0]) begin
              prdata_nxt[7:0] = regs_r.first;
            end else if (hit[1]) begin
              prdata_nxt[7:0] = regs_r.second;
            end
          end
        end
      end
      ST_ACC: begin
        // Transfer ends here; a new setup may follow directly
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `RDATA_ZERO;
    end else begin
      state_r <= state_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ==========================================================
  // Pull-up enable registers

  // Write lands only on the completing edge, low byte lane only
  always_comb begin
    regs_nxt = regs_r;
    if (access_done && apb_req.pwrite && apb_req.pstrb[0]) begin
      if (hit[0]) begin
        // Reserved bit is masked so it stays zero
        regs_nxt.first = apb_req.pwdata[7:0] & `FIRST_WR_MASK;
      end else if (hit[1]) begin
        regs_nxt.second = apb_req.pwdata[7:0] & `SECOND_WR_MASK;
      end
    end
  end

  // All pulls off after reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regs_r.first <= `FIRST_PULL_RST;
      regs_r.second <= `SECOND_PULL_RST;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ==========================================================
  // Pad gating

  // Built from the next register value so the pad follows the write
  // on the same edge; the pin configuration is one cycle behind.
  genvar gi;
  generate
    for (gi = 0; gi < `PULL_WIDTH; gi++) begin : g_pin
      always_comb begin
        // Output or hi-Z pins never see a pull
        pull_first_nxt[gi] = regs_nxt.first[gi] & first_port_in_en[gi] &
                             ~first_port_out_en[gi];
        pull_second_nxt[gi] = regs_nxt.second[gi] & second_port_in_en[gi] &
                              ~second_port_out_en[gi];
      end
    end
  endgenerate

  // Pad controls registered for clean, glitch-free levels
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pull_first_r <= `FIRST_PULL_RST;
      pull_second_r <= `SECOND_PULL_RST;
    end else begin
      pull_first_r <= pull_first_nxt;
      pull_second_r <= pull_second_nxt;
    end
  end

  // ==========================================================
  // Outputs, all straight from flops

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign first_port_pin_pull_on = pull_first_r;
  assign second_port_pin_pull_on = pull_second_r;

  // ==========================================================
  // Assertions

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Write to the second register is stored whole, all eight bits
  property p_second_rw;
    (access_done && apb_req.pwrite && apb_req.pstrb[0] && hit == 2'b10)
    |=> regs_r.second == $past(apb_req.pwdata[7:0]);
  endproperty
  a_second_rw: assert property (p_second_rw)
    else $error("second port register differs from written value");

  // A read of the second register returns the stored byte, upper lanes zero
  property p_second_rd;
    (setup_ph && state_r == ST_IDLE && !apb_req.pwrite && hit == 2'b10)
    |=> prdata_r == {24'h00_0000, $past(regs_r.second)};
  endproperty
  a_second_rd: assert property (p_second_rd)
    else $error("second port register read differs from stored value");

  // A fully input port shows its enables on the pads
  property p_second_on;
    (second_port_in_en == 8'hFF && second_port_out_en == 8'h00)
    |=> pull_second_r == regs_r.second;
  endproperty
  a_second_on: assert property (p_second_on)
    else $error("second port pull does not follow its enable bits");

  // Straight out of reset every pull is off
  property p_reset_clear;
    @(posedge clk_sys) $fell(rst) |-> regs_r.second == 8'h00 &&
      pull_second_r == 8'h00 && pull_first_r == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("pull enables not cleared by reset");

  // Output or hi-Z pins never get a pull
  property p_no_pull_off_input;
    ((pull_second_r & ($past(second_port_out_en) |
      ~$past(second_port_in_en))) == 8'h00) &&
    ((pull_first_r & ($past(first_port_out_en) |
      ~$past(first_port_in_en))) == 8'h00);
  endproperty
  a_no_pull_off_input: assert property (p_no_pull_off_input)
    else $error("pull applied to a pin that is not an input");

  // Low first-port bits follow the written value
  property p_first_low;
    (access_done && apb_req.pwrite && apb_req.pstrb[0] && hit == 2'b01)
    |=> regs_r.first[2:0] == $past(apb_req.pwdata[2:0]);
  endproperty
  a_first_low: assert property (p_first_low)
    else $error("first port low bits not written");

  // Reserved bit and upper lanes read zero
  property p_first_rsvd;
    (setup_ph && !apb_req.pwrite && hit == 2'b01)
    |=> prdata_r[`FIRST_RSVD_BIT] == 1'b0 && prdata_r[31:8] == 24'h00_0000;
  endproperty
  a_first_rsvd: assert property (p_first_rsvd)
    else $error("reserved bit of first port reads nonzero");

  // No change without a completed write
  property p_hold;
    !(access_done && apb_req.pwrite) |=> $stable(regs_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pull register changed without a write");

  // Every setup is answered in exactly one cycle
  property p_answer;
    (setup_ph && state_r == ST_IDLE) |=> pready_r ##1 !pready_r;
  endproperty
  a_answer: assert property (p_answer)
    else $error("access phase not answered in one cycle");

  // On a fully input port the pad follows a write on its completing edge
  property p_pad_follows_write;
    (access_done && apb_req.pwrite && apb_req.pstrb[0] && hit == 2'b10 &&
     second_port_in_en == 8'hFF && second_port_out_en == 8'h00)
    |=> pull_second_r == $past(apb_req.pwdata[7:0]);
  endproperty
  a_pad_follows_write: assert property (p_pad_follows_write)
    else $error("second port pads lag the completing write");

  // Unmapped transfers leave both registers alone
  property p_unmapped_no_write;
    (access_done && hit == 2'b00) |=> $stable(regs_r);
  endproperty
  a_unmapped_no_write: assert property (p_unmapped_no_write)
    else $error("unmapped transfer changed a pull register");

  // Reserved first-port bit is never stored, whatever was written
  property p_first_rsvd_store;
    regs_r.first[`FIRST_RSVD_BIT] == 1'b0;
  endproperty
  a_first_rsvd_store: assert property (p_first_rsvd_store)
    else $error("reserved bit of first port register was set");

  // Main scenarios
  c_write_second: cover property (access_done && apb_req.pwrite && hit == 2'b10);
  c_read_first: cover property (access_done && !apb_req.pwrite && hit == 2'b01);
  c_unmapped: cover property (pslverr_r);
  c_back_to_back: cover property (access_done ##1 access_done);

endmodule

`default_nettype wire

// File: src/pullup_map.svh
// Constants for the port pull-up enable block: register indices,
// field layout and reset values.
// Assumes it is included by its bare name from files under src/.
`ifndef PULLUP_MAP_SVH
`define PULLUP_MAP_SVH

// ==========================================================
// Register indices; byte address is four times the index
`define FIRST_PULL_IDX 16'h30F0
`define SECOND_PULL_IDX 16'h30F1

// ==========================================================
// Field layout
`define PULL_WIDTH 8
`define FIRST_RSVD_BIT 4
`define FIRST_WR_MASK 8'hEF
`define SECOND_WR_MASK 8'hFF

// ==========================================================
// Reset values
`define FIRST_PULL_RST 8'h00
`define SECOND_PULL_RST 8'h00
`define RDATA_ZERO 32'h0000_0000

`endif

// File: src/pullup_pkg.sv
// Types shared by the port pull-up enable block.
// Assumes a plain APB master with 32-bit data and 16-bit addresses.
`default_nettype none

package pullup_pkg;

  // ==========================================================
  // APB request carried as one bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_t;

  // ==========================================================
  // Stored pull-up enables of both ports
  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
  } pull_regs_t;

  // ==========================================================
  // Bus slave phase, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACC = 2'b10
  } apb_state_t;

endpackage

`default_nettype wire

// File: verif/port_pullup_enable_control_tb_top.sv
// Self-checking bench for the port pull-up enable block.
// Assumes the design under src/ and the map header on the include path.
`include "pullup_map.svh"
`default_nettype none

module port_pullup_enable_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pullup_pkg::*;

  // ==========================================================
  // Byte addresses, four times the register index
  localparam logic [15:0] FA = 16'(4 * `FIRST_PULL_IDX);
  localparam logic [15:0] SA = 16'(4 * `SECOND_PULL_IDX);

  // Design connections
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  apb_req_t apb_req;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [7:0] f_out_en, f_in_en, s_out_en, s_in_en, f_pull, s_pull;
  // Reference model of both registers
  int m_first, m_second;
  int comparisons, miscompares;

  always #2.5 clk_sys = ~clk_sys;

  port_pullup_enable_control i_port_pullup_enable_control (
    .clk_sys(clk_sys), .rst(rst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_port_out_en(f_out_en), .first_port_in_en(f_in_en),
    .second_port_out_en(s_out_en), .second_port_in_en(s_in_en),
    .first_port_pin_pull_on(f_pull), .second_port_pin_pull_on(s_pull)
  );

  // ==========================================================
  // Compare and closing
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // A pull is only applied to a pin that acts as an input
  task automatic chk_pads;
    chk("first_pull", 32'(8'(m_first) & f_in_en & ~f_out_en), 32'(f_pull));
    chk("second_pull", 32'(8'(m_second) & s_in_en & ~s_out_en), 32'(s_pull));
  endtask

  // Pin configuration change; pads follow one edge later
  task automatic cfg(input logic [31:0] c);
    @(posedge clk_sys);
    {f_out_en, f_in_en, s_out_en, s_in_en} <= c;
    @(posedge clk_sys);
    #1 chk_pads();
  endtask

  // ==========================================================
  // One APB transfer, checked against the model
  task automatic op(input logic wr, input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] rd;
    logic err;
    int n;
    int exp_rd;
    n = 0;
    exp_rd = (a == FA) ? m_first : ((a == SA) ? m_second : 0);
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: s};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    // A missing answer counts as a mismatch and is reported
    chk("pready", 32'h0000_0001, 32'(pready));
    // Writes land at the completing edge; bit 4 of the first port is kept at 0
    if (wr && s[0] && a == FA) m_first = int'(d[7:0] & 8'hEF);
    if (wr && s[0] && a == SA) m_second = int'(d[7:0]);
    if (!wr) chk("prdata", exp_rd, rd);
    chk("pslverr", 32'(a != FA && a != SA), 32'(err));
    #1 chk_pads();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] a;
    apb_req = '0;
    {f_out_en, f_in_en, s_out_en, s_in_en} = 32'h00FF_00FF;
    void'($urandom(32'h29b2b933));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    op(1'b0, FA, 32'h0000_0000, 4'hF);
    op(1'b0, SA, 32'h0000_0000, 4'hF);
    $display("test reset_values done");
    op(1'b1, FA, 32'hFFFF_FFFF, 4'hF);
    op(1'b1, SA, 32'hFFFF_FFFF, 4'hF);
    op(1'b0, FA, 32'h0000_0000, 4'hF);
    cfg(32'h0000_0000);
    cfg(32'hFF00_FF00);
    cfg(32'hFFFF_FFFF);
    cfg(32'h00FF_00FF);
    // Write on a fully input port: pads follow on the completing edge
    op(1'b1, SA, 32'h0000_00A5, 4'h1);
    op(1'b0, SA, 32'h0000_0000, 4'hF);
    $display("test pin_modes done");
    repeat (300) begin
      cfg($urandom);
      case ($urandom % 3)
        0: a = FA;
        1: a = SA;
        default: a = 16'($urandom) & 16'hFFFC;
      endcase
      op(1'($urandom), a, $urandom, 4'($urandom));
    end
    $display("test random_traffic done");
    // Reset in mid-run, with the bus idle, clears registers and pads
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    m_first = 0;
    m_second = 0;
    #1 chk_pads();
    op(1'b0, FA, 32'h0000_0000, 4'hF);
    op(1'b0, SA, 32'h0000_0000, 4'hF);
    $display("test mid_reset done");
    tally_and_finish();
  end

  // Watchdog against a hung handshake
  initial begin
    #100us;
    miscompares++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
